/* File: ieee488_defines.svh */
`ifndef IEEE488_DEFINES_SVH
`define IEEE488_DEFINES_SVH

// bus geometry
`define ADDR_W 5
`define DATA_W 32

// register byte offsets
`define REG_COMMAND 5'h00
`define REG_STATUS_BYTE 5'h04
`define REG_RESPONSE 5'h08
`define REG_OPER_ENABLE 5'h0C
`define REG_QUES_ENABLE 5'h10
`define REG_OPER_EVENT 5'h14
`define REG_QUES_EVENT 5'h18

// command word layout
`define CMD_OP_MSB 3
`define CMD_OP_LSB 0
`define CMD_ARG_MSB 15
`define CMD_ARG_LSB 8

// command opcodes
`define OP_CLS 4'h1
`define OP_ESE 4'h2
`define OP_ESE_Q 4'h3
`define OP_ESR_Q 4'h4
`define OP_IDN_Q 4'h5
`define OP_OPC 4'h6
`define OP_OPC_Q 4'h7
`define OP_RST 4'h8
`define OP_SRE 4'h9
`define OP_SRE_Q 4'hA
`define OP_STB_Q 4'hB
`define OP_TST_Q 4'hC
`define OP_WAI 4'hD

// status byte and event bit positions
`define STB_QUES 3
`define STB_MAV 4
`define STB_ESB 5
`define STB_MSS 6
`define STB_OPER 7
`define ESR_OPC 0
`define SRE_WMASK 8'hBF

// response layout and characters
`define RESP_VALID 8
`define CH_ZERO 8'h30
`define CH_ONE 8'h31
`define CH_COMMA 8'h2C
`define IDN_LEN 5'h13
`define IDN_FIELD 5'h05
`define IDN_SEP_POS 3'h4
`define ONE_LEFT 5'h01
`define EV_W 16

// reset values
`define RST_MASK8 8'h00
`define RST_MASK16 16'h0000
`define RST_WORD 32'h0000_0000

`endif

/* File: ieee488_pkg.sv */
package ieee488_pkg;

`include "ieee488_defines.svh"

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OPCQ = 4'b0010,
        ST_WAI = 4'b0100,
        ST_TEST = 4'b1000
    } fsm_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [`ADDR_W-1:0] address;
        logic [`DATA_W-1:0] writedata;
    } avs_req_s;

    typedef struct packed {
        fsm_e fsm;
        logic [7:0] ese;
        logic [7:0] sre;
        logic [7:0] esr;
        logic [`EV_W-1:0] oper_ev;
        logic [`EV_W-1:0] ques_ev;
        logic [`EV_W-1:0] oper_en;
        logic [`EV_W-1:0] ques_en;
        logic opc_armed;
        logic resp_idn;
        logic [7:0] resp_val;
        logic [4:0] resp_idx;
        logic [4:0] resp_left;
        logic rd_ack;
        logic [`DATA_W-1:0] readdata;
        logic srq;
        logic selftest_start;
        logic settings_restore;
        logic preset;
        logic results_clear;
    } unit_s;

endpackage

/* File: ieee488_status_command_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ieee488_defines.svh"

module ieee488_status_command_unit #(
    // identity words, four ASCII characters each; values are arbitrary
    parameter logic [31:0] MFR_ID = 32'h4D_46_52_41,
    parameter logic [31:0] MODEL_ID = 32'h4D_44_4C_31,
    parameter logic [31:0] SERIAL_ID = 32'h30_30_30_31,
    parameter logic [31:0] FW_ID = 32'h31_2E_30_30
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ieee488_pkg::avs_req_s avs_req,
    output logic [`DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic no_op_pending,
    input wire logic device_clear,
    input wire logic [7:0] std_event_in,
    input wire logic [`EV_W-1:0] oper_event_in,
    input wire logic [`EV_W-1:0] ques_event_in,
    input wire logic selftest_done,
    input wire logic selftest_fail,
    output logic selftest_start,
    output logic settings_restore,
    output logic preset,
    output logic results_clear,
    output logic srq
);
    import ieee488_pkg::*;

    // a zero byte or a comma inside an identity word breaks the answer
    function automatic logic id_ok(input logic [31:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (w[i*8 +: 8] == 8'h00 || w[i*8 +: 8] == `CH_COMMA) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    if (!(id_ok(MFR_ID) && id_ok(MODEL_ID) && id_ok(SERIAL_ID) &&
          id_ok(FW_ID))) begin : g_id_check
        $error("identity words need printable non-comma characters");
    end

    // the layout macros must fit the bus word and the field slot
    if (`EV_W > `DATA_W || `RESP_VALID >= `DATA_W ||
        `IDN_SEP_POS >= `IDN_FIELD) begin : g_layout_check
        $error("response or event layout does not fit the bus word");
    end

    localparam logic [127:0] IDS = {MFR_ID, MODEL_ID, SERIAL_ID, FW_ID};

    // one character of the identity answer, separators between fields
    function automatic logic [7:0] idn_char(input logic [4:0] idx);
        logic [2:0] fld;
        logic [2:0] pos;
        logic [31:0] word;
        // each field owns a slot of characters closed by its separator
        fld = 3'(idx / `IDN_FIELD);
        pos = 3'(idx % `IDN_FIELD);
        word = IDS[(3 - fld) * 32 +: 32];
        if (pos == `IDN_SEP_POS) begin
            return `CH_COMMA;
        end
        return word[(3 - pos) * 8 +: 8];
    endfunction

    // the whole block state sits in one struct register
    unit_s s;
    unit_s next_s;

    // combinational view of the status byte
    logic esb;
    logic oper_sum;
    logic ques_sum;
    logic mav;
    logic mss;
    logic [7:0] stb_raw;
    logic [7:0] stb;
    logic [7:0] resp_byte;
    logic cmd_blocked;

    // summary bits are pure functions of state, never latched
    always_comb begin
        esb = |(s.esr & s.ese);
        oper_sum = |(s.oper_ev & s.oper_en);
        ques_sum = |(s.ques_ev & s.ques_en);
        mav = (s.resp_left != 5'h00);
        stb_raw = 8'h00;
        stb_raw[`STB_OPER] = oper_sum;
        stb_raw[`STB_ESB] = esb;
        stb_raw[`STB_MAV] = mav;
        stb_raw[`STB_QUES] = ques_sum;
        // bit 6 stays out of its own request term, so no loop forms
        mss = |(stb_raw & s.sre & `SRE_WMASK);
        stb = stb_raw;
        stb[`STB_MSS] = mss;
        resp_byte = s.resp_idn ? idn_char(s.resp_idx) : s.resp_val;
    end

    // commands stall on the bus while a wait, query or test holds
    assign cmd_blocked = (s.fsm != ST_IDLE);

    // reads take two cycles so that read data comes from a flop
    // only command writes stall; other registers stay reachable
    always_comb begin
        avs_waitrequest = 1'b0;
        if (avs_req.read && !s.rd_ack) begin
            avs_waitrequest = 1'b1;
        end else if (avs_req.write && avs_req.address == `REG_COMMAND &&
                     cmd_blocked) begin
            avs_waitrequest = 1'b1;
        end
    end

    assign avs_readdata = s.readdata;
    assign selftest_start = s.selftest_start;
    assign settings_restore = s.settings_restore;
    assign preset = s.preset;
    assign results_clear = s.results_clear;
    assign srq = s.srq;

    // next state: bus, commands, waits and sticky events
    always_comb begin
        logic acc_wr;
        logic acc_rd;
        logic [3:0] op;
        logic [7:0] arg;
        logic [7:0] esr_set;
        logic esr_clr;
        logic ev_clr;
        logic load;
        logic load_idn;
        logic [7:0] load_val;
        acc_wr = avs_req.write && !avs_waitrequest;
        acc_rd = avs_req.read && !avs_waitrequest;
        op = avs_req.writedata[`CMD_OP_MSB:`CMD_OP_LSB];
        arg = avs_req.writedata[`CMD_ARG_MSB:`CMD_ARG_LSB];
        esr_set = std_event_in;
        esr_clr = 1'b0;
        ev_clr = 1'b0;
        load = 1'b0;
        load_idn = 1'b0;
        load_val = 8'h00;

        next_s = s;
        next_s.selftest_start = 1'b0;
        next_s.settings_restore = 1'b0;
        next_s.preset = 1'b0;
        next_s.results_clear = 1'b0;
        next_s.srq = mss;

        // read capture on the first cycle, hand-over on the second
        next_s.rd_ack = 1'b0;
        if (avs_req.read && !s.rd_ack) begin
            next_s.rd_ack = 1'b1;
            // unmapped and write-only offsets read back as zero
            next_s.readdata = `RST_WORD;
            if (avs_req.address == `REG_STATUS_BYTE) begin
                next_s.readdata[7:0] = stb;
            end else if (avs_req.address == `REG_RESPONSE) begin
                next_s.readdata[7:0] = mav ? resp_byte : 8'h00;
                next_s.readdata[`RESP_VALID] = mav;
            end else if (avs_req.address == `REG_OPER_ENABLE) begin
                next_s.readdata[`EV_W-1:0] = s.oper_en;
            end else if (avs_req.address == `REG_QUES_ENABLE) begin
                next_s.readdata[`EV_W-1:0] = s.ques_en;
            end else if (avs_req.address == `REG_OPER_EVENT) begin
                next_s.readdata[`EV_W-1:0] = s.oper_ev;
            end else if (avs_req.address == `REG_QUES_EVENT) begin
                next_s.readdata[`EV_W-1:0] = s.ques_ev;
            end
        end

        // popping the output queue happens at the accepted edge; a byte
        // is popped only if it was handed over as valid and the queue
        // still holds one, so a flush in between cannot underflow it
        if (acc_rd && avs_req.address == `REG_RESPONSE &&
            s.readdata[`RESP_VALID] && mav) begin
            next_s.resp_idx = s.resp_idx + 5'h01;
            next_s.resp_left = s.resp_left - 5'h01;
        end

        // plain register writes
        if (acc_wr && avs_req.address == `REG_OPER_ENABLE) begin
            next_s.oper_en = avs_req.writedata[`EV_W-1:0];
        end else if (acc_wr && avs_req.address == `REG_QUES_ENABLE) begin
            next_s.ques_en = avs_req.writedata[`EV_W-1:0];
        end

        // command interpreter; only reached while idle
        if (acc_wr && avs_req.address == `REG_COMMAND) begin
            case (op)
                `OP_CLS: begin
                    esr_clr = 1'b1;
                    ev_clr = 1'b1;
                    next_s.opc_armed = 1'b0;
                    // masks ese, sre, oper_en, ques_en left alone
                end
                `OP_ESE: begin
                    next_s.ese = arg;
                end
                `OP_ESE_Q: begin
                    load = 1'b1;
                    load_val = s.ese;
                end
                `OP_ESR_Q: begin
                    load = 1'b1;
                    load_val = s.esr;
                    esr_clr = 1'b1;
                end
                `OP_IDN_Q: begin
                    load = 1'b1;
                    load_idn = 1'b1;
                end
                `OP_OPC: begin
                    next_s.opc_armed = 1'b1;
                end
                `OP_OPC_Q: begin
                    next_s.fsm = ST_OPCQ;
                end
                `OP_RST: begin
                    // status registers are left alone; the device functions,
                    // the measurement results and the completion arm are reset
                    next_s.preset = 1'b1;
                    next_s.results_clear = 1'b1;
                    next_s.opc_armed = 1'b0;
                end
                `OP_SRE: begin
                    // bit 6 is the summary itself and is never enabled
                    next_s.sre = arg & `SRE_WMASK;
                end
                `OP_SRE_Q: begin
                    load = 1'b1;
                    load_val = s.sre;
                end
                `OP_STB_Q: begin
                    load = 1'b1;
                    load_val = stb;
                end
                `OP_TST_Q: begin
                    // the engine keeps the settings snapshot; this block
                    // starts it, reports the verdict and pulses the restore after a pass
                    next_s.selftest_start = 1'b1;
                    next_s.fsm = ST_TEST;
                end
                `OP_WAI: begin
                    next_s.fsm = ST_WAI;
                end
                default: begin
                    // unknown opcodes are dropped
                end
            endcase
        end

        // a pending completion fires without holding up the parser
        // a re-arm in the firing cycle is lost, harmless: the bit is sticky
        if (s.opc_armed && no_op_pending) begin
            esr_set[`ESR_OPC] = 1'b1;
            next_s.opc_armed = 1'b0;
        end

        // blocking states release on idle, test end or device clear
        case (s.fsm)
            ST_OPCQ: begin
                if (no_op_pending) begin
                    load = 1'b1;
                    load_val = `CH_ONE;
                    next_s.fsm = ST_IDLE;
                end
            end
            ST_WAI: begin
                if (no_op_pending) begin
                    next_s.fsm = ST_IDLE;
                end
            end
            ST_TEST: begin
                if (selftest_done) begin
                    load = 1'b1;
                    load_val = selftest_fail ? `CH_ONE : `CH_ZERO;
                    // a failed test leaves settings as the test left them
                    next_s.settings_restore = !selftest_fail;
                    next_s.fsm = ST_IDLE;
                end
            end
            default: begin
            end
        endcase

        // a new answer replaces whatever the queue still held
        // limitation: one answer deep, so an unread answer is lost
        if (load) begin
            next_s.resp_idn = load_idn;
            next_s.resp_val = load_val;
            next_s.resp_idx = 5'h00;
            next_s.resp_left = load_idn ? `IDN_LEN : `ONE_LEFT;
        end

        // device clear aborts waits and flushes the output queue
        if (device_clear) begin
            next_s.fsm = ST_IDLE;
            next_s.resp_left = 5'h00;
            // a clear in the test cycle also drops the restore pulse
            next_s.settings_restore = 1'b0;
        end

        // sticky events: a set in the clearing cycle survives
        next_s.esr = (esr_clr ? 8'h00 : s.esr) | esr_set;
        next_s.oper_ev = (ev_clr ? `RST_MASK16 : s.oper_ev) |
                         oper_event_in;
        next_s.ques_ev = (ev_clr ? `RST_MASK16 : s.ques_ev) |
                         ques_event_in;
    end

    // single state register, synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // every field by name, so each reset value stays visible
            s.fsm <= ST_IDLE;
            s.ese <= `RST_MASK8;
            s.sre <= `RST_MASK8;
            s.esr <= `RST_MASK8;
            s.oper_ev <= `RST_MASK16;
            s.ques_ev <= `RST_MASK16;
            s.oper_en <= `RST_MASK16;
            s.ques_en <= `RST_MASK16;
            s.opc_armed <= 1'b0;
            s.resp_idn <= 1'b0;
            s.resp_val <= 8'h00;
            s.resp_idx <= 5'h00;
            s.resp_left <= 5'h00;
            s.rd_ack <= 1'b0;
            s.readdata <= `RST_WORD;
            s.srq <= 1'b0;
            s.selftest_start <= 1'b0;
            s.settings_restore <= 1'b0;
            s.preset <= 1'b0;
            s.results_clear <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire

/* File: op_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module op_engine_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_begin,
    input wire logic fail_mode,
    input wire logic selftest_start,
    output logic no_op_pending,
    output logic selftest_done,
    output logic selftest_fail
);
    logic [3:0] busy;
    logic [2:0] tst;
    // overlapped op lasts 15 cycles, self-test 6
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy <= 4'h0;
            tst <= 3'h0;
        end else begin
            if (op_begin)
                busy <= 4'hF;
            else if (busy != 4'h0)
                busy <= busy - 4'h1;
            if (selftest_start)
                tst <= 3'h6;
            else if (tst != 3'h0)
                tst <= tst - 3'h1;
        end
    end
    assign no_op_pending = (busy == 4'h0);
    assign selftest_done = (tst == 3'h1);
    // fail is inverted outside done so a stale sample shows up
    assign selftest_fail = selftest_done ? fail_mode : !fail_mode;
endmodule
`default_nettype wire

/* File: status_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ieee488_defines.svh"
module status_unit_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ieee488_pkg::avs_req_s avs_req,
    input wire logic avs_waitrequest,
    input wire logic no_op_pending,
    input wire logic device_clear,
    input wire logic selftest_done,
    input wire logic selftest_fail,
    input wire logic selftest_start,
    input wire logic settings_restore,
    input wire logic preset,
    input wire logic results_clear
);
    import ieee488_pkg::*;
    logic cmd_ok;
    logic [3:0] op;
    logic cmd_req;
    // accepted command write, its opcode, and a pending command request
    assign cmd_ok = avs_req.write && !avs_waitrequest &&
        avs_req.address == `REG_COMMAND;
    assign op = avs_req.writedata[3:0];
    assign cmd_req = avs_req.write && avs_req.address == `REG_COMMAND;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_rst_pulse: assert property (cmd_ok && op == `OP_RST |=> preset)
        else $error("preset pulse missing");
    a_clear_pair: assert property (preset |-> results_clear)
        else $error("results clear missing");
    a_preset_cause: assert property (
        preset |-> $past(cmd_ok && op == `OP_RST))
        else $error("preset without command");
    a_tst_start: assert property (
        cmd_ok && op == `OP_TST_Q |=> selftest_start)
        else $error("self-test not started");
    a_restore_cause: assert property (
        settings_restore |-> $past(selftest_done && !selftest_fail))
        else $error("restore without passing test");
    // blocking shows from the next edge; the check looks two edges on, when the next command arrives
    a_wai_hold: assert property (
        cmd_ok && op == `OP_WAI && !no_op_pending && !device_clear
        ##1 !no_op_pending && !device_clear
        ##1 cmd_req && !no_op_pending |-> avs_waitrequest)
        else $error("command ran during wait");
    a_opcq_hold: assert property (
        cmd_ok && op == `OP_OPC_Q && !no_op_pending && !device_clear
        ##1 !no_op_pending && !device_clear
        ##1 cmd_req && !no_op_pending |-> avs_waitrequest)
        else $error("command ran during completion query");
    a_opc_free: assert property (
        cmd_ok && op == `OP_OPC ##2 cmd_req |-> !avs_waitrequest)
        else $error("completion command stalled");
endmodule
bind ieee488_status_command_unit status_unit_monitor u_status_unit_monitor (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_req(avs_req),
    .avs_waitrequest(avs_waitrequest), .no_op_pending(no_op_pending),
    .device_clear(device_clear), .selftest_done(selftest_done),
    .selftest_fail(selftest_fail), .selftest_start(selftest_start),
    .settings_restore(settings_restore), .preset(preset),
    .results_clear(results_clear));
`default_nettype wire

/* File: test_ieee488_status_command_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ieee488_defines.svh"
module test_ieee488_status_command_unit;
    import ieee488_pkg::*;
    // identity words; values are arbitrary
    localparam logic [0:3][31:0] IDW = {32'h41424344, 32'h45464748,
        32'h494A4B4C, 32'h4D4E4F50};
    typedef struct packed {
        logic [15:0] cmd;
        logic [4:0] addr;
        logic [8:0] exp;
    } row_s;
    logic clk_sys, rst_n, device_clear, selftest_done, selftest_fail;
    logic selftest_start, settings_restore, preset, results_clear, srq;
    logic no_op_pending, op_begin, fail_mode, avs_waitrequest, npend;
    logic [31:0] avs_readdata, q;
    logic [7:0] std_ev;
    logic [15:0] oper_ev, ques_ev;
    avs_req_s req;
    int miscompares, checked, nw;
    int restores = 0;
    int presets = 0;
    row_s rows [0:11] = '{
        {16'h3D02, 5'h04, 9'h000}, {16'h0003, 5'h08, 9'h13D},
        {16'hFF09, 5'h04, 9'h000}, {16'h000A, 5'h08, 9'h1BF},
        {16'h0006, 5'h04, 9'h060}, {16'h0004, 5'h08, 9'h101},
        {16'h0004, 5'h08, 9'h100}, {16'h0007, 5'h04, 9'h050},
        {16'h0000, 5'h08, 9'h131}, {16'h0001, 5'h04, 9'h000},
        {16'h0003, 5'h08, 9'h13D}, {16'h0000, 5'h1C, 9'h000}};

    ieee488_status_command_unit #(.MFR_ID(IDW[0]), .MODEL_ID(IDW[1]),
        .SERIAL_ID(IDW[2]), .FW_ID(IDW[3])) u_ieee488_status_command_unit (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_req(req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .no_op_pending(no_op_pending), .device_clear(device_clear),
        .std_event_in(std_ev), .oper_event_in(oper_ev),
        .ques_event_in(ques_ev), .selftest_done(selftest_done),
        .selftest_fail(selftest_fail), .selftest_start(selftest_start),
        .settings_restore(settings_restore), .preset(preset),
        .results_clear(results_clear), .srq(srq));
    op_engine_model u_op_engine_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .op_begin(op_begin), .fail_mode(fail_mode),
        .selftest_start(selftest_start), .no_op_pending(no_op_pending),
        .selftest_done(selftest_done), .selftest_fail(selftest_fail));

    always #20 clk_sys = ~clk_sys;
    // count restore and preset pulses; one of each is expected
    always @(posedge clk_sys) begin
        if (settings_restore === 1'b1)
            restores <= restores + 1;
        if (preset === 1'b1 && results_clear === 1'b1)
            presets <= presets + 1;
    end

    task finish_test;
        begin
            if (miscompares == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            checked++;
            if (g !== e) begin
                miscompares++;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // one bus cycle; waitrequest and read data taken at the same edge
    task bus(input int rd, input logic [4:0] a, input logic [31:0] d);
        begin
            @(posedge clk_sys);
            req.read <= (rd != 0);
            req.write <= (rd == 0);
            req.address <= a;
            req.writedata <= d;
            nw = 0;
            do begin
                @(posedge clk_sys);
                nw++;
            end while (avs_waitrequest !== 1'b0 && nw < 200);
            if (nw >= 200) begin
                miscompares++;
                finish_test();
            end
            q = avs_readdata;
            npend = no_op_pending;
            req.read <= 1'b0;
            req.write <= 1'b0;
        end
    endtask

    task pulse_op;
        begin
            op_begin <= 1'b1;
            @(posedge clk_sys);
            op_begin <= 1'b0;
        end
    endtask

    initial begin
        clk_sys = 0;
        rst_n = 0;
        req = '0;
        {device_clear, op_begin, fail_mode, std_ev, oper_ev, ques_ev} = '0;
        {miscompares, checked} = '0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmp("reset_outputs", {27'h0, preset, results_clear, selftest_start,
            settings_restore, srq}, 32'h0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].cmd != 16'h0)
                bus(0, `REG_COMMAND, {16'h0, rows[i].cmd});
            bus(1, rows[i].addr, 32'h0);
            cmp("table_row", {23'h0, rows[i].exp}, q);
        end
        // events: enabled operation and questionable bits, masked standard
        bus(0, `REG_OPER_ENABLE, 32'h1);
        bus(0, `REG_QUES_ENABLE, 32'h2);
        oper_ev <= 16'h0001;
        ques_ev <= 16'h0002;
        std_ev <= 8'h02;
        @(posedge clk_sys);
        oper_ev <= 16'h0;
        ques_ev <= 16'h0;
        std_ev <= 8'h0;
        bus(1, `REG_STATUS_BYTE, 32'h0);
        cmp("stb_summary", 32'hC8, q);
        cmp("srq_set", 32'h1, {31'h0, srq});
        bus(0, `REG_COMMAND, 32'h0009);
        bus(1, `REG_STATUS_BYTE, 32'h0);
        cmp("stb_no_mss", 32'h88, q);
        cmp("srq_clear", 32'h0, {31'h0, srq});
        bus(0, `REG_COMMAND, 32'h0001);
        bus(1, `REG_OPER_EVENT, 32'h0);
        cmp("oper_cleared", 32'h0, q);
        bus(1, `REG_QUES_EVENT, 32'h0);
        cmp("ques_cleared", 32'h0, q);
        bus(1, `REG_OPER_ENABLE, 32'h0);
        cmp("oper_mask_kept", 32'h1, q);
        bus(1, `REG_QUES_ENABLE, 32'h0);
        cmp("ques_mask_kept", 32'h2, q);
        // identity string, nineteen bytes
        bus(0, `REG_COMMAND, 32'h0005);
        for (int i = 0; i < 19; i++) begin
            bus(1, `REG_RESPONSE, 32'h0);
            cmp("idn_byte", {24'h1, (i % 5 == 4) ? 8'h2C :
                IDW[i / 5][31 - 8 * (i % 5) -: 8]}, q);
        end
        // self-test pass then fail; a held command waits for the result
        for (int i = 0; i < 2; i++) begin
            fail_mode <= i[0];
            bus(0, `REG_COMMAND, 32'h000C);
            bus(0, `REG_COMMAND, 32'h3D02);
            bus(1, `REG_RESPONSE, 32'h0);
            cmp("selftest_result", 32'h130 + i, q);
        end
        cmp("restore_count", 32'h1, restores);
        // completion command with an overlapped op running
        pulse_op();
        bus(0, `REG_COMMAND, 32'h0006);
        bus(0, `REG_COMMAND, 32'h3D02);
        cmp("opc_no_stall", 32'h1, nw);
        bus(1, `REG_STATUS_BYTE, 32'h0);
        cmp("opc_not_yet", 32'h0, q);
        bus(0, `REG_COMMAND, 32'h0007);
        bus(0, `REG_COMMAND, 32'h3D02);
        cmp("opcq_held", 32'h1, npend);
        bus(1, `REG_STATUS_BYTE, 32'h0);
        cmp("opc_done", 32'h30, q);
        bus(1, `REG_RESPONSE, 32'h0);
        cmp("opcq_answer", 32'h131, q);
        // wait command, then wait cut short by device clear
        pulse_op();
        bus(0, `REG_COMMAND, 32'h000D);
        bus(0, `REG_COMMAND, 32'h3D02);
        cmp("wai_held", 32'h1, npend);
        pulse_op();
        bus(0, `REG_COMMAND, 32'h000D);
        fork
            bus(0, `REG_COMMAND, 32'h3D02);
            begin
                repeat (4) @(posedge clk_sys);
                device_clear <= 1'b1;
                @(posedge clk_sys);
                device_clear <= 1'b0;
            end
        join
        cmp("dc_release", 32'h1, {31'h0, nw < 10});
        bus(0, `REG_COMMAND, 32'h0008);
        bus(1, `REG_OPER_ENABLE, 32'h0);
        cmp("rst_keeps_status", 32'h1, q);
        cmp("preset_count", 32'h1, presets);
        // mid-run reset: outputs drop and the standard event enable mask returns to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        cmp("reset_outputs", {27'h0, preset, results_clear, selftest_start,
            settings_restore, srq}, 32'h0);
        rst_n <= 1'b1;
        bus(0, `REG_COMMAND, 32'h0003);
        bus(1, `REG_RESPONSE, 32'h0);
        cmp("reset_mask", 32'h100, q);
        finish_test();
    end
endmodule
`default_nettype wire
